//--- include/eus_defs.vh
// constants of the e-paper update sequencer: offsets, fields, reset values, timing
`ifndef EUS_DEFS_VH
`define EUS_DEFS_VH

// ==================================================================
// register byte offsets on the apb
// ==================================================================
`define EUS_OFS_CTRL      8'h00
`define EUS_OFS_STATUS    8'h04
`define EUS_OFS_UPDSEL    8'h08
`define EUS_OFS_ENTRY     8'h0C
`define EUS_OFS_XADDR     8'h10
`define EUS_OFS_YADDR     8'h14

// ==================================================================
// field positions
// ==================================================================
`define EUS_CTRL_ACTIVATE 0
`define EUS_CTRL_CLR_OVF  1
`define EUS_ST_BUSY       0
`define EUS_ST_OVF        1
`define EUS_ST_WRMODE     2
`define EUS_ST_CLOCK      3
`define EUS_ST_ANALOG     4
`define EUS_SEL_WAVE_SET  3

// ==================================================================
// command codes and reset values
// ==================================================================
`define EUS_CMD_UPDSEL    8'h22
`define EUS_CMD_WRITE_BW  8'h24
`define EUS_RST_UPDSEL    8'hFF
`define EUS_RST_ENTRY     3'h3

// ==================================================================
// plane geometry and stage timing
// ==================================================================
`define EUS_X_LAST        8'h18
`define EUS_Y_LAST        9'h0C7
`define EUS_CLK_NS        4
`define EUS_TEMP_NS       400
`define EUS_WAVE_NS       800
`define EUS_DRIVE_NS      4000
`define EUS_TEMP_CYC      ((`EUS_TEMP_NS + `EUS_CLK_NS - 1) / `EUS_CLK_NS)
`define EUS_WAVE_CYC      ((`EUS_WAVE_NS + `EUS_CLK_NS - 1) / `EUS_CLK_NS)
`define EUS_DRIVE_CYC     ((`EUS_DRIVE_NS + `EUS_CLK_NS - 1) / `EUS_CLK_NS)

`endif

//--- logic/eus_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module eus_fifo #(
    parameter W     = 9,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // clock and reset
    input  wire         pclk,
    input  wire         presetn,
    // fill side
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    // drain side
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    // ==============================================================
    // storage and pointers
    // ==============================================================
    reg [W-1:0] mem [0:DEPTH-1];  // word storage
    reg [AW-1:0] wr_ptr;          // next slot to fill
    reg [AW-1:0] rd_ptr;          // next slot to drain
    reg [AW:0]   count;           // words held, one bit wider so full is honest
    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];

    // pointer wrap, depth need not be a power of two
    function [AW-1:0] eus_inc;
        input [AW-1:0] p;
        begin
            eus_inc = (p == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
        end
    endfunction

    // ==============================================================
    // data array, no reset needed on storage
    // ==============================================================
    always @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // ==============================================================
    // pointers and fill count
    // ==============================================================
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= eus_inc(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= eus_inc(rd_ptr);
            end
            // simultaneous push and pop leaves the count alone
            if (push & ~pop) begin
                count <= count + 1'b1;
            end else if (pop & ~push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // eus_fifo

//--- logic/eus_sequencer.v
// serial command port, stage sequencer and image plane write stepping
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "eus_defs.vh"
module eus_sequencer #(
    parameter        FIFO_DEPTH = 8,
    parameter [15:0] TEMP_CYC   = `EUS_TEMP_CYC,
    parameter [15:0] WAVE_CYC   = `EUS_WAVE_CYC,
    parameter [15:0] DRIVE_CYC  = `EUS_DRIVE_CYC
) (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // serial command port from the host
    input  wire        spi_cs_n,
    input  wire        spi_sclk,
    input  wire        spi_sdin,
    input  wire        spi_dc,
    // stage controls toward the panel
    output reg         busy,
    output reg         clock_on,
    output reg         analog_on,
    output reg         temp_load,
    output reg         waveform_table_load,
    output reg         waveform_set_two,
    output reg         display_drive,
    // black_white_plane write port
    output reg         plane_we,
    output reg  [7:0]  plane_x,
    output reg  [8:0]  plane_y,
    output reg  [7:0]  plane_data
);
    // ==============================================================
    // declarations
    // ==============================================================
    localparam ST_IDLE = 2'h0;     // waiting for activation
    localparam ST_PICK = 2'h1;     // look at the next stage bit
    localparam ST_HOLD = 2'h2;     // stage in progress
    reg  [2:0]  cs_sync;           // chip select synchroniser and history
    reg  [2:0]  sclk_sync;         // serial clock synchroniser and history
    reg  [1:0]  sdin_sync;         // serial data synchroniser
    reg  [1:0]  dc_sync;           // data/command synchroniser
    reg  [6:0]  shift;             // bits gathered so far
    reg  [2:0]  bit_cnt;           // bits of current byte
    reg         rx_valid;          // one assembled byte for the fifo
    reg  [8:0]  rx_word;           // {dc, byte}
    reg         overflow;          // sticky: a byte found the fifo full
    reg  [7:0]  update_sel;        // stage selection byte
    reg  [2:0]  entry_mode;        // {address_update_axis, address_step_direction}
    reg  [7:0]  x_ptr;             // column byte pointer
    reg  [8:0]  y_ptr;             // row pointer
    reg         write_mode;        // streaming into black_white_plane
    reg         expect_sel;        // next data byte is the stage selection
    reg         act_req;           // one-cycle activation from software
    reg  [1:0]  seq_state;         // sequencer state
    reg  [2:0]  stage_idx;         // stage index, 0 looks at bit 7
    reg  [7:0]  run_sel;           // selection latched at activation
    reg  [15:0] wait_cnt;          // cycles left in the current stage
    wire        fifo_in_ready;     // room for a received byte
    wire        fifo_out_valid;    // a byte waits for the interpreter
    wire [8:0]  fifo_out_data;     // {dc, byte} at the head
    wire        cmd_ready;         // interpreter takes bytes while idle
    wire        cmd_take;          // a byte is consumed this cycle
    wire        sclk_rise;         // rising edge of the serial clock
    wire        apb_setup;         // setup phase of an apb transfer
    wire        apb_wr;            // write takes effect at this edge
    wire        stage_bit;         // selection bit of the current stage
    wire        last_stage;        // index at bit 0
    wire        x_inc;             // column steps up
    wire        y_inc;             // row steps up
    wire [8:0]  x_step;            // column after one step
    wire [8:0]  y_step;            // row after one step
    wire        x_wrap;            // column passed its end
    wire        y_wrap;            // row passed its end

    // ==============================================================
    // helper functions
    // ==============================================================
    // one step of a pointer with wrap at either end
    function [8:0] eus_step;
        input [8:0] val;
        input       up;
        input [8:0] last;
        begin
            if (up) begin
                eus_step = (val >= last) ? 9'h000 : val + 9'h001;
            end else begin
                eus_step = (val == 9'h000) ? last : val - 9'h001;
            end
        end
    endfunction

    // true when the step above wrapped
    function eus_wraps;
        input [8:0] val;
        input       up;
        input [8:0] last;
        begin
            eus_wraps = up ? (val >= last) : (val == 9'h000);
        end
    endfunction

    // true for the offsets that hold a register
    function eus_mapped;
        input [7:0] a;
        begin
            eus_mapped = (a == `EUS_OFS_CTRL) | (a == `EUS_OFS_STATUS) | (a == `EUS_OFS_UPDSEL) |
                         (a == `EUS_OFS_ENTRY) | (a == `EUS_OFS_XADDR) | (a == `EUS_OFS_YADDR);
        end
    endfunction

    assign sclk_rise  = sclk_sync[1] & ~sclk_sync[2];
    assign apb_setup  = psel & ~penable;
    assign apb_wr     = psel & penable & pready & pwrite & ~pslverr;
    assign cmd_ready  = (seq_state == ST_IDLE) & ~act_req;
    assign cmd_take   = fifo_out_valid & cmd_ready;
    assign stage_bit  = run_sel[3'h7 - stage_idx];
    assign last_stage = (stage_idx == 3'h7);
    assign x_inc      = entry_mode[0] | entry_mode[1];
    assign y_inc      = entry_mode[1];
    assign x_step     = eus_step({1'b0, x_ptr}, x_inc, {1'b0, `EUS_X_LAST});
    assign y_step     = eus_step(y_ptr, y_inc, `EUS_Y_LAST);
    assign x_wrap     = eus_wraps({1'b0, x_ptr}, x_inc, {1'b0, `EUS_X_LAST});
    assign y_wrap     = eus_wraps(y_ptr, y_inc, `EUS_Y_LAST);

    // ==============================================================
    // serial port: synchronise pins, assemble bytes msb first
    // ==============================================================
    // only the second and later stages feed logic, the first may be metastable
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_sync   <= 3'h7;
            sclk_sync <= 3'h0;
            sdin_sync <= 2'h0;
            dc_sync   <= 2'h0;
            shift     <= 7'h00;
            bit_cnt   <= 3'h0;
            rx_valid  <= 1'b0;
            rx_word   <= 9'h000;
        end else begin
            cs_sync   <= {cs_sync[1:0], spi_cs_n};
            sclk_sync <= {sclk_sync[1:0], spi_sclk};
            sdin_sync <= {sdin_sync[0], spi_sdin};
            dc_sync   <= {dc_sync[0], spi_dc};
            rx_valid  <= 1'b0;
            if (cs_sync[1]) begin
                // deselect drops a partial byte
                bit_cnt <= 3'h0;
            end else if (sclk_rise) begin
                bit_cnt <= bit_cnt + 3'h1;
                shift   <= {shift[5:0], sdin_sync[1]};
                if (bit_cnt == 3'h7) begin
                    // dc low marks a command, high a parameter or pixel byte
                    rx_word  <= {dc_sync[1], shift, sdin_sync[1]};
                    rx_valid <= 1'b1;
                end
            end
        end
    end

    // ==============================================================
    // byte buffer between the serial side and the interpreter
    // ==============================================================
    // the interpreter stalls while a sequence runs, so the fifo really fills
    eus_fifo #(
        .W     (9),
        .DEPTH (FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (rx_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (rx_word),
        .out_valid (fifo_out_valid),
        .out_ready (cmd_ready),
        .out_data  (fifo_out_data)
    );

    // ==============================================================
    // apb slave: zero wait states, registered answer
    // ==============================================================
    // read data and error are prepared in setup, so the access phase ends at once
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            act_req <= 1'b0;
        end else begin
            pready  <= apb_setup;
            pslverr <= apb_setup & ~eus_mapped(paddr);
            act_req <= apb_wr & (paddr == `EUS_OFS_CTRL) & pwdata[`EUS_CTRL_ACTIVATE] &
                       (seq_state == ST_IDLE) & ~act_req;
            if (apb_setup) begin
                case (paddr)
                    `EUS_OFS_STATUS: prdata <= {27'h0000000, analog_on, clock_on, write_mode, overflow, busy};
                    `EUS_OFS_UPDSEL: prdata <= {24'h000000, update_sel};
                    `EUS_OFS_ENTRY:  prdata <= {29'h00000000, entry_mode};
                    `EUS_OFS_XADDR:  prdata <= {24'h000000, x_ptr};
                    `EUS_OFS_YADDR:  prdata <= {23'h000000, y_ptr};
                    default:         prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ==============================================================
    // command interpreter and plane writes
    // ==============================================================
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            update_sel <= `EUS_RST_UPDSEL;
            entry_mode <= `EUS_RST_ENTRY;
            x_ptr      <= 8'h00;
            y_ptr      <= 9'h000;
            write_mode <= 1'b0;
            expect_sel <= 1'b0;
            overflow   <= 1'b0;
            plane_we   <= 1'b0;
            plane_x    <= 8'h00;
            plane_y    <= 9'h000;
            plane_data <= 8'h00;
        end else begin
            plane_we <= 1'b0;
            // a lost byte sets the flag even in the cycle software clears it
            if (rx_valid & ~fifo_in_ready) begin
                overflow <= 1'b1;
            end else if (apb_wr & (paddr == `EUS_OFS_CTRL) & pwdata[`EUS_CTRL_CLR_OVF]) begin
                overflow <= 1'b0;
            end
            if (cmd_take & ~fifo_out_data[8]) begin
                // any command byte ends streaming and starts its own decode
                write_mode <= (fifo_out_data[7:0] == `EUS_CMD_WRITE_BW);
                expect_sel <= (fifo_out_data[7:0] == `EUS_CMD_UPDSEL);
            end else if (cmd_take & expect_sel) begin
                update_sel <= fifo_out_data[7:0];
                expect_sel <= 1'b0;
            end else if (cmd_take & write_mode) begin
                // bytes are stored as sent: 1 white, 0 black
                plane_we   <= 1'b1;
                plane_x    <= x_ptr;
                plane_y    <= y_ptr;
                plane_data <= fifo_out_data[7:0];
                if (!entry_mode[2]) begin
                    // x first, y steps when x wraps
                    x_ptr <= x_step[7:0];
                    if (x_wrap) begin
                        y_ptr <= y_step;
                    end
                end else begin
                    // y first, x steps when y wraps
                    y_ptr <= y_step;
                    if (y_wrap) begin
                        x_ptr <= x_step[7:0];
                    end
                end
            end
            // software setup; the interpreter only runs on fifo bytes while idle
            if (apb_wr) begin
                case (paddr)
                    `EUS_OFS_UPDSEL: update_sel <= pwdata[7:0];
                    `EUS_OFS_ENTRY:  entry_mode <= pwdata[2:0];
                    `EUS_OFS_XADDR:  x_ptr      <= pwdata[7:0];
                    `EUS_OFS_YADDR:  y_ptr      <= pwdata[8:0];
                    default:         ;
                endcase
            end
        end
    end

    // ==============================================================
    // stage sequencer: walks bits 7 down to 0 of the selection
    // ==============================================================
    // bit3 is no stage of its own, it only picks the waveform set
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_state           <= ST_IDLE;
            stage_idx           <= 3'h0;
            run_sel             <= 8'h00;
            wait_cnt            <= 16'h0000;
            busy                <= 1'b0;
            clock_on            <= 1'b0;
            analog_on           <= 1'b0;
            temp_load           <= 1'b0;
            waveform_table_load <= 1'b0;
            waveform_set_two    <= 1'b0;
            display_drive       <= 1'b0;
        end else begin
            case (seq_state)
                ST_IDLE: begin
                    if (act_req) begin
                        run_sel          <= update_sel;
                        waveform_set_two <= update_sel[`EUS_SEL_WAVE_SET];
                        stage_idx        <= 3'h0;
                        busy             <= 1'b1;
                        seq_state        <= ST_PICK;
                    end
                end
                ST_PICK: begin
                    // start the stage if selected, else skip in one cycle
                    wait_cnt <= 16'h0001;
                    if (stage_bit) begin
                        seq_state <= ST_HOLD;
                        case (stage_idx)
                            3'h0: clock_on <= 1'b1;
                            3'h1: analog_on <= 1'b1;
                            3'h2: begin
                                temp_load <= 1'b1;
                                wait_cnt  <= TEMP_CYC;
                            end
                            3'h3: begin
                                waveform_table_load <= 1'b1;
                                wait_cnt            <= WAVE_CYC;
                            end
                            3'h5: begin
                                display_drive <= 1'b1;
                                wait_cnt      <= DRIVE_CYC;
                            end
                            3'h6: analog_on <= 1'b0;
                            3'h7: clock_on <= 1'b0;
                            default: seq_state <= ST_PICK;
                        endcase
                        if (stage_idx == 3'h4) begin
                            stage_idx <= stage_idx + 3'h1;
                        end
                    end else if (last_stage) begin
                        busy      <= 1'b0;
                        seq_state <= ST_IDLE;
                    end else begin
                        stage_idx <= stage_idx + 3'h1;
                    end
                end
                ST_HOLD: begin
                    if (wait_cnt > 16'h0001) begin
                        wait_cnt <= wait_cnt - 16'h0001;
                    end else begin
                        temp_load           <= 1'b0;
                        waveform_table_load <= 1'b0;
                        display_drive       <= 1'b0;
                        if (last_stage) begin
                            busy      <= 1'b0;
                            seq_state <= ST_IDLE;
                        end else begin
                            stage_idx <= stage_idx + 3'h1;
                            seq_state <= ST_PICK;
                        end
                    end
                end
                default: seq_state <= ST_IDLE;
            endcase
        end
    end
endmodule // eus_sequencer

//--- verification/eus_sequencer_properties.sv
// assertions on the update sequencer ports
`timescale 1ns/1ps
module eus_props (
    // clock, reset and bus answer
    input wire pclk, presetn, psel, penable, pready, pslverr,
    // stage levels and plane strobe
    input wire busy, clock_on, analog_on, temp_load, waveform_table_load, display_drive, plane_we
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no answer after setup");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_clk_first; $rose(analog_on) |-> clock_on; endproperty
    a_clk_first: assert property (p_clk_first) else $error("analog before clock");
    property p_an_off_first; $fell(clock_on) |-> !analog_on; endproperty
    a_an_off_first: assert property (p_an_off_first) else $error("clock off before analog");
    property p_wave_clk; waveform_table_load |-> clock_on && busy; endproperty
    a_wave_clk: assert property (p_wave_clk) else $error("table load unclocked");
    // bench sets the temperature stage to three cycles
    property p_temp_len; $rose(temp_load) |-> temp_load[*3] ##1 !temp_load; endproperty
    a_temp_len: assert property (p_temp_len) else $error("temperature stage length");
    property p_drive_pwr; display_drive |-> clock_on && analog_on && busy; endproperty
    a_drive_pwr: assert property (p_drive_pwr) else $error("drive unpowered");
    // back-to-back bytes may strobe on consecutive cycles, but never while a sequence runs
    property p_we_idle; plane_we |-> !busy; endproperty
    a_we_idle: assert property (p_we_idle) else $error("plane write during sequence");
    property p_busy_end; $fell(busy) |-> !temp_load && !waveform_table_load && !display_drive; endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy fell mid stage");
endmodule // eus_props
bind eus_sequencer eus_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .busy(busy), .clock_on(clock_on), .analog_on(analog_on),
    .temp_load(temp_load), .waveform_table_load(waveform_table_load), .display_drive(display_drive),
    .plane_we(plane_we));

//--- verification/eus_host.sv
// host model driving the serial command port
`timescale 1ns/1ps
module eus_host (
    // serial pins toward the device
    output logic spi_cs_n, spi_sclk, spi_sdin, spi_dc
);
    initial {spi_cs_n, spi_sclk, spi_sdin, spi_dc} = 4'b1000;
    // one byte, msb first; sclk idles low between bytes
    // pins move 1 ns after a pclk edge; the trailing 3 ns keep each call in clock phase
    task send(input d, input [7:0] b);
        #1 spi_cs_n = 1'b0;
        spi_dc = d;
        for (int i = 7; i >= 0; i--) begin
            spi_sdin = b[i];
            #40 spi_sclk = 1'b1;
            #40 spi_sclk = 1'b0;
        end
        #3;
    endtask
    // deselect; data line no longer holds its last bit
    task stop;
        #41 spi_cs_n = 1'b1;
        spi_sdin = ~spi_sdin;
        #3;
    endtask
endmodule // eus_host

//--- verification/eus_sequencer_test.sv
// self-checking bench of the update sequencer
`timescale 1ns/1ps
`include "eus_defs.vh"
module eus_sequencer_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, busy_q = 0, c = 0, an = 0;
    logic [7:0] paddr = 0, s;
    logic [31:0] pwdata = 0;
    wire [31:0] prdata;
    wire pready, pslverr, busy, clock_on, analog_on, temp_load, waveform_table_load, waveform_set_two;
    wire display_drive, plane_we, cs_n, sclk, sdin, dc;
    wire [7:0] plane_x, plane_data;
    wire [8:0] plane_y;
    int fails = 0, checks = 0;
    logic [32:0] rq[$];
    logic [24:0] pq[$];
    logic [5:0] sq[$];
    logic [3:0] seen;
    logic [7:0] codes[10] = '{8'hC0, 8'h03, 8'h91, 8'h99, 8'hB1, 8'hB9, 8'hC7, 8'hCF, 8'hF7, 8'hFF};
    // short stage counts keep the run brief; long drive lets the fifo overflow
    eus_sequencer #(.TEMP_CYC(16'h3), .WAVE_CYC(16'h2), .DRIVE_CYC(16'hBB8)) i_dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .spi_cs_n(cs_n), .spi_sclk(sclk),
        .spi_sdin(sdin), .spi_dc(dc), .busy(busy), .clock_on(clock_on), .analog_on(analog_on),
        .temp_load(temp_load), .waveform_table_load(waveform_table_load), .waveform_set_two(waveform_set_two),
        .display_drive(display_drive), .plane_we(plane_we), .plane_x(plane_x), .plane_y(plane_y),
        .plane_data(plane_data));
    eus_host i_host (.spi_cs_n(cs_n), .spi_sclk(sclk), .spi_sdin(sdin), .spi_dc(dc));
    initial forever #2 pclk = ~pclk;
    task check(input [63:0] v, input [63:0] e);
        checks++;
        if (v !== e) begin
            fails++;
            $display("unexpected %0t: got %h want %h", $time, v, e);
        end
    endtask
    // apb transfer; read expectations queued before the answer edge
    task apb(input w, input [7:0] a, input [31:0] d, input [32:0] e);
        if (!w) rq.push_back(e);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    // select stages, note the expected outcome, then activate
    task act(input [7:0] v);
        apb(1, `EUS_OFS_UPDSEL, {24'h0, v}, 0);
        c = (c | v[7]) & !v[0];
        an = (an | v[6]) & !v[1];
        sq.push_back({v[5], v[4], v[2], v[3] & (v[4] | v[2]), c, an});
        apb(1, `EUS_OFS_CTRL, 1, 0);
        repeat (4) @(posedge pclk);
    endtask
    task idle;
        for (int n = 0; n < 5000 && busy !== 1'b0; n++) @(posedge pclk);
        check(busy, 0);
    endtask
    task px(input [7:0] x, input [8:0] y);
        s = 8'($urandom);
        pq.push_back({x, y, s});
        i_host.send(1, s);
    endtask
    // ==================== monitors
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) check({pslverr, prdata}, rq.pop_front());
        if (plane_we !== 1'b0) check({plane_x, plane_y, plane_data}, pq.size() ? pq.pop_front() : 25'h0);
        if (busy === 1'b1) seen = (busy_q ? seen : 4'h0) | {temp_load, waveform_table_load, display_drive,
            waveform_set_two & (waveform_table_load | display_drive)};
        if (busy_q === 1'b1 && busy === 1'b0) check({seen, clock_on, analog_on}, sq.pop_front());
        busy_q = busy;
    end
    task finish_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #200000 fails++;
        finish_test;
    end
    initial begin
        void'($urandom(32'h1e5f));
        repeat (8) @(posedge pclk);
        presetn <= 1;
        repeat (3) @(posedge pclk);
        apb(0, `EUS_OFS_UPDSEL, 0, 33'hFF);
        apb(0, `EUS_OFS_ENTRY, 0, 33'h3);
        apb(0, 8'h1C, 0, {1'b1, 32'h0});
        i_host.send(0, `EUS_CMD_UPDSEL);
        i_host.send(1, 8'hC0);
        i_host.stop;
        repeat (20) @(posedge pclk);
        apb(0, `EUS_OFS_UPDSEL, 0, 33'hC0);
        foreach (codes[i]) begin act(codes[i]); idle; end
        act(8'hFF);
        i_host.send(0, 8'h00);
        repeat (9) i_host.send(1, 8'($urandom));
        i_host.stop;
        idle;
        apb(0, `EUS_OFS_STATUS, 0, 33'h2);
        apb(1, `EUS_OFS_CTRL, 2, 0);
        apb(0, `EUS_OFS_STATUS, 0, 33'h0);
        apb(1, `EUS_OFS_XADDR, 32'h17, 0);
        apb(1, `EUS_OFS_YADDR, 32'h5, 0);
        i_host.send(0, `EUS_CMD_WRITE_BW);
        px(8'h17, 9'h5); px(8'h18, 9'h5); px(8'h0, 9'h6);
        apb(1, `EUS_OFS_ENTRY, 32'h4, 0);
        apb(1, `EUS_OFS_XADDR, 0, 0);
        apb(1, `EUS_OFS_YADDR, 0, 0);
        px(8'h0, 9'h0); px(8'h18, 9'hC7); px(8'h18, 9'hC6);
        apb(1, `EUS_OFS_ENTRY, 32'h1, 0);
        apb(1, `EUS_OFS_XADDR, 32'h18, 0);
        apb(1, `EUS_OFS_YADDR, 0, 0);
        px(8'h18, 9'h0); px(8'h0, 9'hC7);
        apb(0, `EUS_OFS_XADDR, 0, 33'h1);
        apb(0, `EUS_OFS_YADDR, 0, 33'hC7);
        i_host.send(0, 8'h00);
        i_host.send(1, 8'h5A);
        i_host.stop;
        repeat (20) @(posedge pclk);
        finish_test;
    end
endmodule // eus_sequencer_test
